// file: src/clock_gen_cfg.svh
`ifndef CLOCK_GEN_CFG_SVH
`define CLOCK_GEN_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_CTRL_ONE 8'h00
`define OFS_CTRL_TWO 8'h04
`define OFS_TRIM 8'h08
`define OFS_STATUS_CTRL 8'h0c
`define OFS_CTRL_THREE 8'h10

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_CTRL_ONE 8'h04
`define RST_CTRL_TWO 8'h00
`define RST_TRIM 8'h80
`define RST_CTRL_THREE 8'h01

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CLK_SRC_HI 7
`define CLK_SRC_LO 6
`define REF_DIV_HI 5
`define REF_DIV_LO 3
`define INT_REF_BIT 2
`define FREQ_RANGE_BIT 5
`define LOW_POWER_BIT 3
`define EXT_REF_SEL_BIT 2
`define EXT_REF_EN_BIT 1
`define LOCK_LOSS_BIT 7
`define LOCK_BIT 6
`define PLL_ST_BIT 5
`define INT_REF_ST_BIT 4
`define CLK_ST_HI 3
`define CLK_ST_LO 2
`define OSC_READY_BIT 1
`define FINE_TRIM_POS 0
`define LL_IRQ_EN_BIT 7
`define LOOP_SEL_BIT 6
`define CLK_MON_EN_BIT 5
`define MULT_HI 3
`define MULT_LO 0

// ----------------------------------------------------------------
// encodings
// ----------------------------------------------------------------
`define CS_FLL 2'h0
`define CS_IRC 2'h1
`define CS_ERC 2'h2
`define CS_PLL 2'h3
`define MULT_STEP 6'h04
`define MULT_MAX 6'h28
`define MULT_MAX_CODE 4'ha
`define MULT_RSVD_CODE 4'h0
`define FLL_FACTOR 11'h400

`endif

// file: src/clock_gen_ctrl.sv
`timescale 1ns/1ps
`include "clock_gen_cfg.svh"
// Operation
// - osc ready sets after start-up when ext ref selected and in use.
// - osc ready clears only on ext select clear or internal mode without enable.
// - fine trim set lengthens reference period one step, clear shortens it.
// - lock-loss status with irq enable raises interrupt; enable clear raises none.
// - loop select 0 picks fll, pll off; 1 picks pll, fll off.
// - monitor enable gives reset request on external clock loss, else monitor off.
// - multiplier codes 1 to 10 give factors 4 to 40; 0 reserved.
// - multiplier codes 11 and above act as factor 40.
// - nine mode states with only the allowed transitions.
// - reset leaves the block in fll engaged internal mode.
// - fll internal mode on source 00, internal ref, fll, divider 000.
// - fll internal routes fll to main and debug clocks, pll off.
// - fll external on source 00, external ref, fll; software sets divider.
// - fll external routes fll to main and debug clocks, pll off.
// - status codes: 00 fll, 01 internal, 10 external, 11 pll; source 00 picks fll or pll, 01 and 10 as status, 11 matches no mode.
// - lock-loss status sticky, set on lock lost, cleared by write one.
module clock_gen_ctrl import clock_gen_pkg::*; #(
  parameter int ADDR_W = 8,
  parameter int DATA_W = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [ADDR_W-1:0] adr_i,
  input wire logic [DATA_W-1:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [DATA_W-1:0] dat_o,
  output logic ack_o,
  input wire logic osc_init_done_i,
  input wire logic lock_i,
  input wire logic ext_clock_lost_i,
  input wire logic stop_i,
  output logic [1:0] main_clk_sel_o,
  output logic debug_clk_fll_o,
  output logic fll_enable_o,
  output logic pll_enable_o,
  output logic ref_internal_o,
  output logic osc_enable_o,
  output logic [2:0] ref_divider_o,
  output logic [8:0] trim_o,
  output logic [5:0] pll_factor_o,
  output logic irq_o,
  output logic reset_req_o
);

  if (ADDR_W < 8 || DATA_W != 32) begin : g_bad_params
    $error("clock_gen_ctrl needs ADDR_W >= 8 and DATA_W == 32");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] o);
    return a == ADDR_W'(o);
  endfunction : hit

  function automatic logic [5:0] mult_factor(input logic [3:0] code);
    if (code == `MULT_RSVD_CODE) return `MULT_STEP;
    if (code > `MULT_MAX_CODE) return `MULT_MAX;
    return {code, 2'b00};
  endfunction : mult_factor

  function automatic logic [1:0] clk_src(input mode_t m);
    logic [1:0] s;
    s = `CS_FLL;
    if (m inside {ST_FLL_BYP_INT, ST_LP_INT}) s = `CS_IRC;
    if (m inside {ST_FLL_BYP_EXT, ST_PLL_BYP_EXT, ST_LP_EXT}) s = `CS_ERC;
    if (m == ST_PLL_ENG_EXT) s = `CS_PLL;
    return s;
  endfunction : clk_src

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] meta_q;
  logic [2:0] sync_q;
  logic osc_done_s;
  logic lock_s;
  logic lost_s;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
    end else if (ce_i) begin
      meta_q <= {ext_clock_lost_i, lock_i, osc_init_done_i};
      sync_q <= meta_q;
    end
  end

  assign osc_done_s = sync_q[0];
  assign lock_s = sync_q[1];
  assign lost_s = sync_q[2];

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------
  logic [7:0] ctrl_one_q;
  logic [7:0] ctrl_two_q;
  logic [7:0] trim_q;
  logic [7:0] ctrl_three_q;
  logic fine_trim_q;
  logic lock_loss_q;
  logic osc_ready_q;
  logic lock_prev_q;
  logic [1:0] css_q;
  logic iref_st_q;
  logic pll_st_q;
  logic ack_q;
  logic [DATA_W-1:0] dat_q;
  logic req;
  logic wr;
  logic [7:0] rd_byte;

  assign req = cyc_i && stb_i;
  // writes land on the edge where the master samples ack
  assign wr = req && we_i && ack_q && sel_i[0];

  always_comb begin
    rd_byte = 8'h00;
    if (hit(adr_i, `OFS_CTRL_ONE)) rd_byte = ctrl_one_q;
    else if (hit(adr_i, `OFS_CTRL_TWO)) rd_byte = ctrl_two_q;
    else if (hit(adr_i, `OFS_TRIM)) rd_byte = trim_q;
    else if (hit(adr_i, `OFS_CTRL_THREE)) rd_byte = ctrl_three_q;
    else if (hit(adr_i, `OFS_STATUS_CTRL)) begin
      rd_byte[`LOCK_LOSS_BIT] = lock_loss_q;
      rd_byte[`LOCK_BIT] = lock_prev_q;
      rd_byte[`PLL_ST_BIT] = pll_st_q;
      rd_byte[`INT_REF_ST_BIT] = iref_st_q;
      rd_byte[`CLK_ST_HI:`CLK_ST_LO] = css_q;
      rd_byte[`OSC_READY_BIT] = osc_ready_q;
      rd_byte[`FINE_TRIM_POS] = fine_trim_q;
    end
  end

  // unmapped addresses still ack, reading zero and dropping writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else if (ce_i) begin
      ack_q <= req && !ack_q;
      if (req && !ack_q) dat_q <= {24'h0, rd_byte};
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_one_q <= `RST_CTRL_ONE;
      ctrl_two_q <= `RST_CTRL_TWO;
      trim_q <= `RST_TRIM;
      ctrl_three_q <= `RST_CTRL_THREE;
      fine_trim_q <= 1'b0;
    end else if (ce_i && wr) begin
      if (hit(adr_i, `OFS_CTRL_ONE)) ctrl_one_q <= dat_i[7:0];
      if (hit(adr_i, `OFS_CTRL_TWO)) ctrl_two_q <= dat_i[7:0];
      if (hit(adr_i, `OFS_TRIM)) trim_q <= dat_i[7:0];
      if (hit(adr_i, `OFS_CTRL_THREE)) ctrl_three_q <= dat_i[7:0];
      if (hit(adr_i, `OFS_STATUS_CTRL)) fine_trim_q <= dat_i[`FINE_TRIM_POS];
    end
  end

  logic ext_sel;
  logic ext_en;
  logic loop_sel;
  logic ll_irq_en;
  logic clk_mon_en;

  assign ext_sel = ctrl_two_q[`EXT_REF_SEL_BIT];
  assign ext_en = ctrl_two_q[`EXT_REF_EN_BIT];
  assign loop_sel = ctrl_three_q[`LOOP_SEL_BIT];
  assign ll_irq_en = ctrl_three_q[`LL_IRQ_EN_BIT];
  assign clk_mon_en = ctrl_three_q[`CLK_MON_EN_BIT];

  // ----------------------------------------------------------------
  // mode machine
  // ----------------------------------------------------------------
  clock_mode_if mif ();
  mode_t mode;

  assign mif.clock_source_select = ctrl_one_q[`CLK_SRC_HI:`CLK_SRC_LO];
  assign mif.internal_ref_select = ctrl_one_q[`INT_REF_BIT];
  assign mif.reference_divider = ctrl_one_q[`REF_DIV_HI:`REF_DIV_LO];
  assign mif.loop_select = loop_sel;
  assign mif.low_power = ctrl_two_q[`LOW_POWER_BIT];
  assign mif.stop = stop_i;
  assign mode = mif.mode;

  clock_mode_fsm u_mode_fsm (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .mif(mif)
  );

  logic ext_mode;
  logic int_mode;
  logic fll_mode;
  logic fll_en_d;
  logic pll_en_d;

  assign ext_mode = mode inside {ST_FLL_ENG_EXT, ST_FLL_BYP_EXT, ST_PLL_ENG_EXT, ST_PLL_BYP_EXT,
                                 ST_LP_EXT};
  assign int_mode = mode inside {ST_FLL_ENG_INT, ST_FLL_BYP_INT, ST_LP_INT};
  assign fll_mode = mode inside {ST_FLL_ENG_INT, ST_FLL_ENG_EXT, ST_FLL_BYP_INT, ST_FLL_BYP_EXT};
  assign fll_en_d = !loop_sel && fll_mode;
  assign pll_en_d = loop_sel && mode inside {ST_PLL_ENG_EXT, ST_PLL_BYP_EXT};

  // ----------------------------------------------------------------
  // oscillator ready and lock loss
  // ----------------------------------------------------------------
  logic osc_set;
  logic osc_clr;
  logic lock_loss_set;
  logic lock_loss_clr;

  assign osc_set = ext_sel && (ext_en || ext_mode) && osc_done_s;
  assign osc_clr = !ext_sel || (int_mode && !ext_en);
  // lock is only watched while a loop runs, so low-power entry is no loss
  assign lock_loss_set = lock_prev_q && !lock_s && (fll_en_d || pll_en_d);
  assign lock_loss_clr = wr && hit(adr_i, `OFS_STATUS_CTRL) && dat_i[`LOCK_LOSS_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_ready_q <= 1'b0;
    end else if (ce_i) begin
      if (osc_set) osc_ready_q <= 1'b1;
      else if (osc_clr) osc_ready_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lock_loss_q <= 1'b0;
      lock_prev_q <= 1'b0;
    end else if (ce_i) begin
      lock_prev_q <= lock_s && (fll_en_d || pll_en_d);
      if (lock_loss_set) lock_loss_q <= 1'b1;
      else if (lock_loss_clr) lock_loss_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // status and outputs
  // ----------------------------------------------------------------
  // stop holds the last routing so the clocks stay static
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      css_q <= `CS_FLL;
      iref_st_q <= 1'b1;
      pll_st_q <= 1'b0;
      main_clk_sel_o <= `CS_FLL;
      debug_clk_fll_o <= 1'b1;
      ref_internal_o <= 1'b1;
      fll_enable_o <= 1'b0;
      pll_enable_o <= 1'b0;
      osc_enable_o <= 1'b0;
      ref_divider_o <= 3'h0;
      trim_o <= 9'h000;
      pll_factor_o <= `MULT_STEP;
      irq_o <= 1'b0;
      reset_req_o <= 1'b0;
    end else if (ce_i) begin
      if (mode != ST_STOP) begin
        css_q <= clk_src(mode);
        iref_st_q <= int_mode;
        pll_st_q <= mode inside {ST_PLL_ENG_EXT, ST_PLL_BYP_EXT};
        main_clk_sel_o <= clk_src(mode);
        debug_clk_fll_o <= fll_mode;
        ref_internal_o <= int_mode;
      end
      fll_enable_o <= fll_en_d;
      pll_enable_o <= pll_en_d;
      osc_enable_o <= ext_en || ext_mode;
      ref_divider_o <= ctrl_one_q[`REF_DIV_HI:`REF_DIV_LO];
      trim_o <= {trim_q, fine_trim_q};
      pll_factor_o <= mult_factor(ctrl_three_q[`MULT_HI:`MULT_LO]);
      irq_o <= ll_irq_en && lock_loss_q;
      reset_req_o <= clk_mon_en && lost_s;
    end
  end

  assign ack_o = ack_q;
  assign dat_o = dat_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_irq_raise: assert property (ce_i && ll_irq_en && lock_loss_q |=> irq_o)
    else $error("no interrupt with lock loss and enable set");
  a_irq_quiet: assert property (ce_i && !ll_irq_en |=> !irq_o)
    else $error("interrupt raised while disabled");
  a_loop_select: assert property (ce_i && loop_sel |=> !fll_enable_o)
    else $error("fll running with pll selected");
  a_monitor_reset: assert property (ce_i && lost_s |=> reset_req_o == $past(clk_mon_en))
    else $error("reset request does not follow monitor enable");
  a_lock_loss_sticky: assert property (ce_i && lock_loss_q && !lock_loss_clr |=> lock_loss_q)
    else $error("lock loss status dropped without a clear");
  a_lock_loss_set: assert property (ce_i && lock_loss_set |=> lock_loss_q)
    else $error("lock loss not recorded");
  a_osc_ready: assert property (ce_i && osc_set |=> osc_ready_q)
    else $error("oscillator ready not set");
  a_osc_clear: assert property (ce_i && !osc_clr && !osc_set && osc_ready_q |=> osc_ready_q)
    else $error("oscillator ready cleared without cause");
  a_mult_clamp: assert property (ce_i && ctrl_three_q[3:0] > `MULT_MAX_CODE
    |=> pll_factor_o == `MULT_MAX)
    else $error("reserved multiplier code not clamped to 40");

endmodule : clock_gen_ctrl

// file: src/clock_gen_pkg.sv
package clock_gen_pkg;

  typedef enum logic [8:0] {
    ST_FLL_ENG_INT = 9'h001,
    ST_FLL_ENG_EXT = 9'h002,
    ST_FLL_BYP_INT = 9'h004,
    ST_FLL_BYP_EXT = 9'h008,
    ST_PLL_ENG_EXT = 9'h010,
    ST_PLL_BYP_EXT = 9'h020,
    ST_LP_INT = 9'h040,
    ST_LP_EXT = 9'h080,
    ST_STOP = 9'h100
  } mode_t;

endpackage : clock_gen_pkg

// file: src/clock_mode_fsm.sv
`timescale 1ns/1ps
`include "clock_gen_cfg.svh"
module clock_mode_fsm import clock_gen_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  clock_mode_if.fsm mif
);

  // ----------------------------------------------------------------
  // decode of the requested mode
  // ----------------------------------------------------------------
  // settings that match no mode leave the current one in place
  function automatic mode_t target_mode(input logic [1:0] cs, input logic int_ref,
                                        input logic pll_sel, input logic lp,
                                        input logic [2:0] div, input mode_t cur);
    mode_t m;
    m = cur;
    case (cs)
      `CS_FLL: begin
        if (int_ref && !pll_sel && div == 3'h0) m = ST_FLL_ENG_INT;
        else if (!int_ref) m = pll_sel ? ST_PLL_ENG_EXT : ST_FLL_ENG_EXT;
      end
      `CS_IRC: if (int_ref && !pll_sel) m = lp ? ST_LP_INT : ST_FLL_BYP_INT;
      `CS_ERC: if (!int_ref) m = lp ? ST_LP_EXT : (pll_sel ? ST_PLL_BYP_EXT : ST_FLL_BYP_EXT);
      default: m = cur;
    endcase
    return m;
  endfunction : target_mode

  function automatic logic legal_step(input mode_t from, input mode_t to);
    logic ok;
    ok = 1'b0;
    case (from)
      ST_FLL_ENG_INT, ST_FLL_ENG_EXT: ok = to inside {ST_FLL_ENG_INT, ST_FLL_ENG_EXT,
                                                     ST_FLL_BYP_INT, ST_FLL_BYP_EXT};
      ST_FLL_BYP_INT: ok = to inside {ST_FLL_ENG_INT, ST_FLL_ENG_EXT, ST_FLL_BYP_EXT, ST_LP_INT};
      ST_FLL_BYP_EXT: ok = to inside {ST_FLL_ENG_INT, ST_FLL_ENG_EXT, ST_FLL_BYP_INT,
                                      ST_PLL_BYP_EXT, ST_LP_EXT};
      ST_PLL_BYP_EXT: ok = to inside {ST_FLL_BYP_EXT, ST_PLL_ENG_EXT, ST_LP_EXT};
      ST_PLL_ENG_EXT: ok = (to == ST_PLL_BYP_EXT);
      ST_LP_INT: ok = (to == ST_FLL_BYP_INT);
      ST_LP_EXT: ok = to inside {ST_FLL_BYP_EXT, ST_PLL_BYP_EXT};
      default: ok = 1'b0;
    endcase
    return ok || from == to;
  endfunction : legal_step

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mode_t mode_q;
  mode_t resume_q;
  mode_t tgt;

  assign tgt = target_mode(mif.clock_source_select, mif.internal_ref_select,
                           mif.loop_select, mif.low_power,
                           mif.reference_divider, mode_q);
  assign mif.mode = mode_q;

  // a jump that skips a step holds the mode; software walks the path
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= ST_FLL_ENG_INT;
      resume_q <= ST_FLL_ENG_INT;
    end else if (ce_i) begin
      case (mode_q)
        ST_STOP: if (!mif.stop) mode_q <= resume_q;
        default: begin
          if (mif.stop) begin
            resume_q <= mode_q;
            mode_q <= ST_STOP;
          end else if (legal_step(mode_q, tgt)) begin
            mode_q <= tgt;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_reset_mode: assert property (@(posedge clk_i) rst_i && ce_i |=> mode_q == ST_FLL_ENG_INT)
    else $error("mode after reset is not the internal fll mode");

  a_legal_moves: assert property (@(posedge clk_i) disable iff (rst_i)
    ($past(mode_q) != ST_STOP && mode_q != ST_STOP) |-> legal_step($past(mode_q), mode_q))
    else $error("mode moved along a path that is not allowed");

endmodule : clock_mode_fsm

// file: src/clock_mode_if.sv
`timescale 1ns/1ps
interface clock_mode_if;
  import clock_gen_pkg::*;

  logic [1:0] clock_source_select;
  logic internal_ref_select;
  logic loop_select;
  logic low_power;
  logic [2:0] reference_divider;
  logic stop;
  mode_t mode;

  modport ctrl (
    output clock_source_select, internal_ref_select, loop_select,
    output low_power, reference_divider, stop,
    input mode
  );
  modport fsm (
    input clock_source_select, internal_ref_select, loop_select,
    input low_power, reference_divider, stop,
    output mode
  );
endinterface : clock_mode_if

// file: verif/ext_osc_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// crystal and loop model at the far side of the clock generator
// ----------------------------------------------------------------
module ext_osc_model #(
  parameter int START_CYC = 16,
  parameter int LOCK_CYC = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic osc_enable_i,
  input wire logic fll_enable_i,
  input wire logic pll_enable_i,
  input wire logic drop_lock_i,
  input wire logic drop_clock_i,
  output logic osc_init_done_o,
  output logic lock_o,
  output logic ext_clock_lost_o
);
  logic [7:0] start_q;
  logic [7:0] lock_q;

  // start-up only counts while the oscillator is asked for
  always_ff @(posedge clk_i) begin
    if (rst_i || !osc_enable_i) begin
      start_q <= 8'h00;
      osc_init_done_o <= 1'b0;
    end else if (start_q == 8'(START_CYC - 1)) begin
      osc_init_done_o <= 1'b1;
    end else begin
      start_q <= start_q + 8'h01;
    end
  end

  // lock is lost at once when disturbed, regained slowly
  always_ff @(posedge clk_i) begin
    if (rst_i || !(fll_enable_i || pll_enable_i) || drop_lock_i) begin
      lock_q <= 8'h00;
      lock_o <= 1'b0;
    end else if (lock_q == 8'(LOCK_CYC - 1)) begin
      lock_o <= 1'b1;
    end else begin
      lock_q <= lock_q + 8'h01;
    end
  end

  assign ext_clock_lost_o = drop_clock_i;
endmodule : ext_osc_model

// file: verif/fll_pll_clock_generator_ctrl_tb.sv
`timescale 1ns/1ps
`include "clock_gen_cfg.svh"
module fll_pll_clock_generator_ctrl_tb import clock_gen_pkg::*;;
  logic clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, drop_lock, drop_clock, ce_i, stop_i;
  logic [3:0] sel_i, lane;
  logic [7:0] adr_i, rd, lfsr, wr;
  logic [31:0] dat_i, dat_o;
  logic osc_done, lock, lost, dbg_fll, fll_en, pll_en, ref_int, osc_en, irq_o, rst_req;
  logic [1:0] clk_sel;
  logic [2:0] div;
  logic [8:0] trim;
  logic [5:0] factor;
  int n_fail, checked, i;

  clock_gen_ctrl i_clock_gen_ctrl (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o),
    .ack_o(ack_o), .osc_init_done_i(osc_done), .lock_i(lock), .ext_clock_lost_i(lost),
    .stop_i(stop_i), .main_clk_sel_o(clk_sel), .debug_clk_fll_o(dbg_fll),
    .fll_enable_o(fll_en), .pll_enable_o(pll_en), .ref_internal_o(ref_int),
    .osc_enable_o(osc_en), .ref_divider_o(div), .trim_o(trim), .pll_factor_o(factor),
    .irq_o(irq_o), .reset_req_o(rst_req));

  ext_osc_model i_ext_osc_model (.clk_i(clk_i), .rst_i(rst_i), .osc_enable_i(osc_en),
    .fll_enable_i(fll_en), .pll_enable_i(pll_en), .drop_lock_i(drop_lock),
    .drop_clock_i(drop_clock), .osc_init_done_o(osc_done), .lock_o(lock),
    .ext_clock_lost_o(lost));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] next_lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : next_lfsr

  // code 0 falls back to the smallest factor by design choice
  function automatic logic [5:0] exp_factor(input logic [3:0] code);
    if (code == 4'h0) return 6'h04;
    if (code > 4'ha) return 6'h28;
    return {code, 2'b00};
  endfunction : exp_factor

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // classic single cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    int t;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    sel_i <= lane;
    adr_i <= a;
    dat_i <= {24'h000000, d};
    t = 0;
    do begin
      @(posedge clk_i);
      t++;
    end while (ack_o !== 1'b1 && t < 50);
    if (t >= 50) check(32'h0, 32'h1);
    rd = dat_o[7:0];
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i <= 1'b0;
  endtask : bus

  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize

  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  initial begin
    #(25 * 20000);
    n_fail++;
    summarize();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_i = 1'b1;
    {cyc_i, stb_i, we_i, drop_lock, drop_clock} = 5'h00;
    ce_i = 1'b1;
    stop_i = 1'b0;
    sel_i = 4'h1;
    lane = 4'h1;
    adr_i = 8'h00;
    dat_i = 32'h0;
    n_fail = 0;
    checked = 0;
    lfsr = 8'h1b;
    tick(2);
    rst_i <= 1'b0;
    tick(3);
    bus(0, `OFS_CTRL_THREE, 8'h00);
    check(rd, 8'h01);
    check({clk_sel, dbg_fll, fll_en, pll_en, ref_int}, 6'h0d);
    bus(0, 8'h40, 8'h00);
    check(rd, 8'h00);
    // sticky lock loss and its request
    tick(12);
    bus(1, `OFS_STATUS_CTRL, 8'h80);
    bus(1, `OFS_CTRL_THREE, 8'h81);
    drop_lock <= 1'b1;
    tick(8);
    check(irq_o, 1'b1);
    drop_lock <= 1'b0;
    tick(12);
    bus(1, `OFS_STATUS_CTRL, 8'h00);
    bus(0, `OFS_STATUS_CTRL, 8'h00);
    check(rd[7], 1'b1);
    bus(1, `OFS_STATUS_CTRL, 8'h80);
    bus(0, `OFS_STATUS_CTRL, 8'h00);
    check(rd[7], 1'b0);
    tick(2);
    check(irq_o, 1'b0);
    bus(1, `OFS_CTRL_THREE, 8'h01);
    drop_lock <= 1'b1;
    tick(8);
    check(irq_o, 1'b0);
    drop_lock <= 1'b0;
    tick(12);
    bus(1, `OFS_STATUS_CTRL, 8'h80);
    // every multiplier code, reserved ones included
    for (i = 0; i < 16; i++) begin
      bus(1, `OFS_CTRL_THREE, 8'(i));
      tick(3);
      check(factor, exp_factor(4'(i)));
      bus(0, `OFS_CTRL_THREE, 8'h00);
      check(rd, 8'(i));
    end
    // coarse trim copied by software, fine trim step on top
    for (i = 0; i < 6; i++) begin
      lfsr = next_lfsr(lfsr);
      wr = lfsr;
      bus(1, `OFS_TRIM, wr);
      bus(1, `OFS_STATUS_CTRL, {7'h00, wr[0]});
      tick(3);
      check(trim, {wr, wr[0]});
      bus(0, `OFS_TRIM, 8'h00);
      check(rd, wr);
    end
    // a write without the low byte lane is acked and dropped
    lane = 4'h2;
    bus(1, `OFS_TRIM, ~wr);
    lane = 4'h1;
    bus(0, `OFS_TRIM, 8'h00);
    check(rd, wr);
    bus(1, `OFS_STATUS_CTRL, 8'h00);
    bus(1, `OFS_CTRL_THREE, 8'h41);
    tick(4);
    // no pll mode is reachable from the default mode, so both loops rest
    check({fll_en, pll_en}, 2'b00);
    bus(1, `OFS_CTRL_THREE, 8'h01);
    tick(4);
    check({fll_en, pll_en}, 2'b10);
    // walk engaged ext, bypassed ext, bypassed int, engaged int, oscillator selected
    bus(1, `OFS_CTRL_TWO, 8'h04);
    for (i = 0; i < 4; i++) begin
      wr = (i == 0) ? 8'h18 : (i == 1) ? 8'h98 : (i == 2) ? 8'h44 : 8'h04;
      bus(1, `OFS_CTRL_ONE, wr);
      tick(30);
      check(clk_sel, wr[7:6]);
      check({ref_int, div, dbg_fll}, {wr[2], wr[5:3], 1'b1});
      bus(0, `OFS_STATUS_CTRL, 8'h00);
      check(rd[3:1], {wr[7:6], ~wr[2]});
    end
    // stop parks the loops and holds the routing, release resumes
    stop_i <= 1'b1;
    tick(3);
    check({clk_sel, fll_en, pll_en}, 4'h0);
    stop_i <= 1'b0;
    tick(3);
    check({clk_sel, fll_en}, 3'h1);
    // monitor request on clock loss, tested with the external reference enabled
    bus(1, `OFS_CTRL_TWO, 8'h06);
    bus(1, `OFS_CTRL_THREE, 8'h21);
    // a low enable freezes the synchroniser, so no request yet
    ce_i <= 1'b0;
    drop_clock <= 1'b1;
    tick(6);
    check(rst_req, 1'b0);
    ce_i <= 1'b1;
    tick(6);
    check(rst_req, 1'b1);
    bus(1, `OFS_CTRL_THREE, 8'h01);
    tick(4);
    check(rst_req, 1'b0);
    drop_clock <= 1'b0;
    tick(4);
    summarize();
  end
endmodule : fll_pll_clock_generator_ctrl_tb
